// ===== errq_class.sv
// Purpose: Maps an error code onto its status class bits
// Assumes: Codes are signed 16-bit
// Notes: Purely combinational
`timescale 1ns/10ps
`include "errq_defines.svh"
module errq_class
  import errq_pkg::*;
(
  input err_code_t code,
  input wire logic valid,
  output logic [7:0] bits
);
  function automatic logic in_rng(err_code_t c, err_code_t lo, err_code_t hi);
    return (c >= lo) && (c <= hi);
  endfunction
  wire cmd_hit = in_rng(code, `CMD_LO, `CMD_HI);
  wire exe_hit = in_rng(code, `EXE_LO, `EXE_HI);
  // Positive codes count here too, as device class
  wire dev_hit = in_rng(code, `DEV_LO, `DEV_HI) || (code > 16'sd0);
  wire qry_hit = in_rng(code, `QRY_LO, `QRY_HI);
  always_comb begin
    bits = 8'h00;
    if (valid) begin
      bits[`ESR_CMD] = cmd_hit;
      bits[`ESR_EXEC] = exe_hit;
      bits[`ESR_DEVICE] = dev_hit;
      bits[`ESR_QUERY] = qry_hit;
    end
  end
endmodule // errq_class

// ===== errq_defines.svh
// Purpose: Offsets, field positions, codes and reset values for the queue
// Assumes: 32-bit APB data, one word per register
// Notes: Included by every design file
`ifndef ERRQ_DEFINES_SVH
`define ERRQ_DEFINES_SVH

`define EQ_DEPTH 8
`define EQ_AW 3
`define EQ_CW 16

`define OFF_POST 12'h000
`define OFF_READ 12'h004
`define OFF_CTRL 12'h008
`define OFF_COUNT 12'h00C
`define OFF_ESR 12'h010
`define OFF_CAUSE 12'h014

`define CTRL_CLS 0

`define ESR_QUERY 2
`define ESR_DEVICE 3
`define ESR_EXEC 4
`define ESR_CMD 5

`define CODE_NONE 16'sh0000
`define CODE_OVERFLOW (-16'sd350)
`define CODE_CMD_GEN (-16'sd100)
`define CODE_SYNTAX (-16'sd102)
`define CODE_PAR_MORE (-16'sd108)
`define CODE_PAR_LESS (-16'sd109)
`define CODE_HDR (-16'sd110)
`define CODE_HDR_UNDEF (-16'sd113)
`define CODE_NUM_CHAR (-16'sd121)
`define CODE_CHAR_DATA (-16'sd140)
`define CODE_STR_DATA (-16'sd150)
`define CODE_STR_BAD (-16'sd151)
`define CODE_EXE_GEN (-16'sd200)
`define CODE_PROTECT (-16'sd203)
`define CODE_PARAM (-16'sd220)

`define CMD_LO (-16'sd199)
`define CMD_HI (-16'sd100)
`define EXE_LO (-16'sd299)
`define EXE_HI (-16'sd200)
`define DEV_LO (-16'sd399)
`define DEV_HI (-16'sd300)
`define QRY_LO (-16'sd499)
`define QRY_HI (-16'sd400)

`define ESR_RESET 8'h00
`endif

// ===== errq_mem.sv
// Purpose: Storage for queued error codes
// Assumes: One write and one read port, same clock
// Notes: Read data comes out of a register
`timescale 1ns/10ps
`include "errq_defines.svh"
module errq_mem
  import errq_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [`EQ_AW-1:0] waddr,
  input err_code_t wdata,
  input wire logic [`EQ_AW-1:0] raddr,
  output err_code_t rdata
);
  err_code_t mem [`EQ_DEPTH];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // errq_mem

// ===== errq_monitor.sv
// Purpose: Port checker for the error queue
// Assumes: One clock, sync active-low reset
// Notes: Bound to the top module
`timescale 1ns/10ps
module errq_monitor
  import errq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic PARSE_ERR_VALID,
  input wire logic [3:0] PARSE_ERR_CAUSE,
  input wire logic EXEC_ERR_VALID,
  input wire logic [3:0] EXEC_ERR_CAUSE,
  input wire logic EXEC_EVAL_DONE,
  input wire logic CLS_CMD,
  input wire logic QUEUE_EMPTY,
  input wire logic [7:0] ESR_CLASS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire pv = PARSE_ERR_VALID;
  wire xv = EXEC_ERR_VALID;
  wire signed [15:0] wcode = PWDATA[15:0];
  // Software post alone, so priority cannot mask it
  wire wr_post = PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000
    && !pv && !xv && !CLS_CMD;
  sequence s_rd_empty;
    QUEUE_EMPTY && !pv && !xv && !CLS_CMD && PSEL && !PENABLE
      && !PWRITE && PADDR == 12'h004;
  endsequence
  property p_empty_zero;
    s_rd_empty |-> ##2 PRDATA == 32'h0;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty read");
  property p_cls; CLS_CMD |=> QUEUE_EMPTY && ESR_CLASS == 8'h00; endproperty
  a_cls: assert property (p_cls) else $error("clear missed");
  property p_cmd;
    pv && !xv && PARSE_ERR_CAUSE < 4'hA && !CLS_CMD |=> ESR_CLASS[5];
  endproperty
  a_cmd: assert property (p_cmd) else $error("command bit");
  property p_exe;
    $fell(xv) && EXEC_EVAL_DONE && EXEC_ERR_CAUSE > 4'h9 && !pv
      && !CLS_CMD |=> ESR_CLASS[4];
  endproperty
  a_exe: assert property (p_exe) else $error("execution bit");
  property p_eval;
    xv && !EXEC_EVAL_DONE && QUEUE_EMPTY && !pv && !PSEL |=> QUEUE_EMPTY;
  endproperty
  a_eval: assert property (p_eval) else $error("early post");
  // Software post lands one edge after the ready edge
  property p_dev; wr_post && wcode > 0 |-> ##2 ESR_CLASS[3]; endproperty
  a_dev: assert property (p_dev) else $error("device bit");
  property p_qry;
    wr_post && wcode <= -16'sd400 && wcode >= -16'sd499
      |-> ##2 ESR_CLASS[2];
  endproperty
  a_qry: assert property (p_qry) else $error("query bit");
  property p_sticky;
    ESR_CLASS != 8'h00 && !CLS_CMD && !PSEL && !$past(PSEL)
      |=> (ESR_CLASS & $past(ESR_CLASS)) == $past(ESR_CLASS);
  endproperty
  a_sticky: assert property (p_sticky) else $error("class bit lost");
endmodule // errq_monitor

bind instrument_error_queue errq_monitor u_mon (.REF_CLK, .RST_N, .PSEL,
  .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
  .PARSE_ERR_VALID, .PARSE_ERR_CAUSE, .EXEC_ERR_VALID, .EXEC_ERR_CAUSE,
  .EXEC_EVAL_DONE, .CLS_CMD, .QUEUE_EMPTY, .ESR_CLASS);

// ===== errq_partner.sv
// Purpose: Parser and execution stage posting errors
// Assumes: Called just after a rising edge
// Notes: Causes 0..9 parse, 10..12 execution
`timescale 1ns/10ps
module errq_partner (
  input wire logic clk,
  output logic perr_v,
  output logic [3:0] perr_c,
  output logic xerr_v,
  output logic [3:0] xerr_c,
  output logic eval_done
);
  initial begin
    {perr_v, perr_c, xerr_v, xerr_c, eval_done} = '0;
  end
  task automatic post(input logic [3:0] c);
    if (c < 4'hA) begin
      perr_v <= 1'b1;
      perr_c <= c;
      @(posedge clk);
      perr_v <= 1'b0;
      perr_c <= ~c;
    end else begin
      xerr_v <= 1'b1;
      xerr_c <= c;
      repeat (2) @(posedge clk);
      xerr_v <= 1'b0;
      eval_done <= 1'b1;
      @(posedge clk);
      eval_done <= 1'b0;
      xerr_c <= ~c;
    end
    @(posedge clk);
  endtask
endmodule // errq_partner

// ===== errq_pkg.sv
// Purpose: Shared types for the error queue
// Assumes: Defines header included first
// Notes: Cause codes select the posted error
`include "errq_defines.svh"
package errq_pkg;
  typedef logic signed [`EQ_CW-1:0] err_code_t;
  typedef enum logic [3:0] {
    C_CMD_GEN, C_SYNTAX, C_PAR_MORE, C_PAR_LESS, C_HDR, C_HDR_UNDEF,
    C_NUM_CHAR, C_CHAR_DATA, C_STR_DATA, C_STR_BAD,
    C_EXE_GEN, C_PROTECT, C_PARAM
  } cause_t;
  typedef struct packed {
    logic valid;
    err_code_t code;
  } post_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// ===== instrument_error_queue.sv
// Purpose: Error queue and status classifier over APB
// Assumes: Single clock, synchronous active-low reset
// Notes: Functional notes
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "errq_defines.svh"
module instrument_error_queue
  import errq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PARSE_ERR_VALID,
  input wire logic [3:0] PARSE_ERR_CAUSE,
  input wire logic EXEC_ERR_VALID,
  input wire logic [3:0] EXEC_ERR_CAUSE,
  input wire logic EXEC_EVAL_DONE,
  input wire logic CLS_CMD,
  output logic QUEUE_EMPTY,
  output logic [7:0] ESR_CLASS
);
  localparam logic [`EQ_AW:0] DEPTH_C = (`EQ_AW+1)'(`EQ_DEPTH);

  function automatic err_code_t cause_code(logic [3:0] c);
    case (cause_t'(c))
      C_CMD_GEN: return `CODE_CMD_GEN;
      C_SYNTAX: return `CODE_SYNTAX;
      C_PAR_MORE: return `CODE_PAR_MORE;
      C_PAR_LESS: return `CODE_PAR_LESS;
      C_HDR: return `CODE_HDR;
      C_HDR_UNDEF: return `CODE_HDR_UNDEF;
      C_NUM_CHAR: return `CODE_NUM_CHAR;
      C_CHAR_DATA: return `CODE_CHAR_DATA;
      C_STR_DATA: return `CODE_STR_DATA;
      C_STR_BAD: return `CODE_STR_BAD;
      C_EXE_GEN: return `CODE_EXE_GEN;
      C_PROTECT: return `CODE_PROTECT;
      C_PARAM: return `CODE_PARAM;
      default: return `CODE_CMD_GEN;
    endcase
  endfunction

  // Pending execution error waits for evaluation to finish
  logic exec_hold_q, exec_hold_d;
  logic [3:0] exec_cause_q, exec_cause_d;
  logic [`EQ_AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [`EQ_AW:0] count_q, count_d;
  logic [7:0] esr_q, esr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pslverr_q, empty_q, acc1_q;
  logic rd_pend_q;
  logic sw_post_q;
  err_code_t sw_code_q;
  err_code_t mem_rdata;

  wire setup = PSEL && !PENABLE;
  wire acc = PSEL && PENABLE && pready_q;
  wire wr_acc = acc && PWRITE;
  wire rd_setup = setup && !PWRITE;
  wire hit_post = PADDR == `OFF_POST;
  wire hit_read = PADDR == `OFF_READ;
  wire hit_ctrl = PADDR == `OFF_CTRL;
  wire hit_cnt = PADDR == `OFF_COUNT;
  wire hit_esr = PADDR == `OFF_ESR;
  wire hit_cause = PADDR == `OFF_CAUSE;
  wire mapped = hit_post | hit_read | hit_ctrl | hit_cnt | hit_esr | hit_cause;

  wire cls = CLS_CMD || (wr_acc && hit_ctrl && PWDATA[`CTRL_CLS]);
  wire pop = rd_setup && hit_read && (count_q != '0);
  // Clear on the ready edge, after the read word was captured
  wire esr_rd = acc && !PWRITE && hit_esr;

  wire exec_now = exec_hold_q && EXEC_EVAL_DONE;

  // Parse first, then execution, then software
  post_t p0, p1, p2;
  assign p0 = '{valid: PARSE_ERR_VALID, code: cause_code(PARSE_ERR_CAUSE)};
  assign p1 = '{valid: exec_now, code: cause_code(exec_cause_q)};
  assign p2 = '{valid: sw_post_q, code: sw_code_q};

  logic [7:0] cls0, cls1, cls2;
  errq_class u_cls0 (.code(p0.code), .valid(p0.valid), .bits(cls0));
  errq_class u_cls1 (.code(p1.code), .valid(p1.valid), .bits(cls1));
  errq_class u_cls2 (.code(p2.code), .valid(p2.valid), .bits(cls2));

  // Enqueue walk; overflow writes the overflow code into the last slot with the one port write
  logic we;
  logic [`EQ_AW-1:0] waddr;
  err_code_t wdata;
  logic [7:0] new_bits;
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    count_d = count_q;
    rd_ptr_d = rd_ptr_q;
    we = 1'b0;
    waddr = wr_ptr_q;
    wdata = `CODE_NONE;
    new_bits = cls0 | cls1 | cls2;
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 1'b1;
      count_d = count_q - 1'b1;
    end
    // One memory write per cycle: first valid post wins the port
    if (p0.valid || p1.valid || p2.valid) begin
      we = 1'b1;
      wdata = p0.valid ? p0.code : (p1.valid ? p1.code : p2.code);
      if (count_d == DEPTH_C || (count_d == DEPTH_C - 1'b1 &&
          (32'(p0.valid) + 32'(p1.valid) + 32'(p2.valid)) > 32'd1)) begin
        waddr = wr_ptr_q - 1'b1;
        if (count_d != DEPTH_C) begin
          waddr = wr_ptr_q;
          wr_ptr_d = wr_ptr_q + 1'b1;
          count_d = count_d + 1'b1;
        end
        wdata = `CODE_OVERFLOW;
        new_bits[`ESR_DEVICE] = 1'b1;
      end else begin
        wr_ptr_d = wr_ptr_q + 1'b1;
        count_d = count_d + 1'b1;
        if ((32'(p0.valid) + 32'(p1.valid) + 32'(p2.valid)) > 32'd1) begin
          // Extra simultaneous posts count as lost; kept simple
          new_bits[`ESR_DEVICE] = 1'b1;
        end
      end
    end
    if (cls) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
      we = 1'b0;
    end
    if (!cls && pop && count_d == '0) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
    end
  end

  // Sticky class bits, set beats read-clear
  always_comb begin
    esr_d = esr_q;
    if (cls || esr_rd) begin
      esr_d = 8'h00;
    end
    esr_d = esr_d | new_bits;
  end

  always_comb begin
    exec_hold_d = exec_hold_q;
    exec_cause_d = exec_cause_q;
    if (exec_now) begin
      exec_hold_d = 1'b0;
    end
    if (EXEC_ERR_VALID) begin
      exec_hold_d = 1'b1;
      exec_cause_d = EXEC_ERR_CAUSE;
    end
    if (cls) begin
      exec_hold_d = 1'b0;
    end
  end

  errq_mem u_mem (
    .clk(REF_CLK), .we(we), .waddr(waddr), .wdata(wdata),
    .raddr(rd_ptr_q), .rdata(mem_rdata)
  );

  wire [31:0] queue_word = rd_pend_q ? 32'(signed'(mem_rdata)) : 32'h0;
  always_comb begin
    prdata_d = 32'h0;
    if (hit_read) prdata_d = queue_word;
    if (hit_cnt) prdata_d = 32'(count_q);
    if (hit_esr) prdata_d = {24'h0, esr_q};
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      esr_q <= `ESR_RESET;
      exec_hold_q <= 1'b0;
      exec_cause_q <= 4'h0;
      pready_q <= 1'b0;
      acc1_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
      rd_pend_q <= 1'b0;
      sw_post_q <= 1'b0;
      sw_code_q <= `CODE_NONE;
      empty_q <= 1'b1;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      esr_q <= esr_d;
      exec_hold_q <= exec_hold_d;
      exec_cause_q <= exec_cause_d;
      // One wait state: read word settles before ready rises
      acc1_q <= setup;
      pready_q <= acc1_q;
      pslverr_q <= acc1_q && !mapped;
      if (setup) rd_pend_q <= pop;
      if (acc1_q) prdata_q <= prdata_d;
      sw_post_q <= wr_acc && hit_post && !cls;
      sw_code_q <= err_code_t'(PWDATA[`EQ_CW-1:0]);
      empty_q <= (count_d == '0);
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  assign QUEUE_EMPTY = empty_q;
  assign ESR_CLASS = esr_q;
endmodule // instrument_error_queue

// ===== instrument_error_queue_bench.sv
// Purpose: Self-checking bench for the error queue
// Assumes: Read data stands with ready
// Notes: Queue model mirrors every result
`timescale 1ns/10ps
module instrument_error_queue_bench;
  import errq_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CLS_CMD = 1'b0;
  apb_req_t req = '0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, QUEUE_EMPTY, pv, xv, ed, slverr;
  logic [3:0] pc, xc;
  logic [7:0] ESR_CLASS;
  logic [15:0] lf = 16'h76B3;
  int failures = 0, compares = 0, esr = 0, q[$];
  int codes[13] = '{-100, -102, -108, -109, -110, -113, -121, -140,
    -150, -151, -200, -203, -220};
  always #25 REF_CLK = ~REF_CLK;
  instrument_error_queue dut (.REF_CLK, .RST_N, .PSEL(req.psel),
    .PENABLE(req.penable), .PWRITE(req.pwrite), .PADDR(req.paddr),
    .PWDATA(req.pwdata), .PRDATA, .PREADY, .PSLVERR,
    .PARSE_ERR_VALID(pv), .PARSE_ERR_CAUSE(pc), .EXEC_ERR_VALID(xv),
    .EXEC_ERR_CAUSE(xc), .EXEC_EVAL_DONE(ed), .CLS_CMD, .QUEUE_EMPTY,
    .ESR_CLASS);
  errq_partner u_far (.clk(REF_CLK), .perr_v(pv), .perr_c(pc),
    .xerr_v(xv), .xerr_c(xc), .eval_done(ed));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Overflow keeps the oldest seven
  function automatic int cls_of(int c);
    return c >= -199 && c <= -100 ? 32 : c >= -299 && c <= -200 ? 16
      : c >= -499 && c <= -400 ? 4 : c > 0 || (c >= -399 && c <= -300)
      ? 8 : 0;
  endfunction
  function automatic void push(int c);
    if (q.size() == 8) begin
      q[7] = -350;
      esr |= 8;
    end else begin
      q.push_back(c);
    end
    esr |= cls_of(c);
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge REF_CLK);
    req.penable <= 1'b1;
    // Ready stands a whole cycle, so mid-cycle sight matches the edge
    do begin
      @(negedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      close_out();
    end
    slverr = PSLVERR;
    r = PRDATA;
    @(posedge REF_CLK);
    req <= '{1'b0, 1'b0, 1'b0, a, ~d};
    @(posedge REF_CLK);
  endtask
  task automatic pop;
    logic [31:0] r;
    apb(1'b0, 12'h004, 32'h0, r);
    check(r, q.size() ? q.pop_front() : 0);
  endtask
  initial begin
    logic [31:0] r;
    int c;
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    check(QUEUE_EMPTY, 1'b1);
    check(ESR_CLASS, 8'h00);
    pop();
    $display("test 1 done");
    for (int i = 0; i < 13; i++) begin
      u_far.post(4'((i + 10) % 13));
      push(codes[(i + 10) % 13]);
    end
    check(ESR_CLASS, esr);
    repeat (9) pop();
    check(QUEUE_EMPTY, 1'b1);
    u_far.post(4'h0);
    push(-100);
    pop();
    $display("test 2 done");
    u_far.post(4'h1);
    CLS_CMD <= 1'b1;
    @(posedge REF_CLK);
    CLS_CMD <= 1'b0;
    @(posedge REF_CLK);
    q.delete();
    esr = 0;
    check(QUEUE_EMPTY, 1'b1);
    check(ESR_CLASS, 8'h00);
    pop();
    $display("test 3 done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      c = i[0] ? int'(lf % 1000) + 1 : -400 - int'(lf % 100);
      apb(1'b1, 12'h000, 32'(c), r);
      push(c);
    end
    // Unmapped place must leave queue alone
    apb(1'b1, 12'h020, 32'h0, r);
    check(slverr, 1'b1);
    apb(1'b0, 12'h010, 32'h0, r);
    check(r, esr);
    esr = 0;
    check(ESR_CLASS, 8'h00);
    repeat (4) pop();
    $display("test 4 done");
    close_out();
  end
endmodule // instrument_error_queue_bench
